// *** hdl/gate_ctrl_pkg.sv ***
package gate_ctrl_pkg;

  // clock and watchdog timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

  localparam logic [6:0] WD_SHORT_MIN_MS = 7'h04;
  localparam logic [6:0] WD_SHORT_MAX_MS = 7'h28;
  localparam logic [6:0] WD_LONG_MIN_MS  = 7'h0a;
  localparam logic [6:0] WD_LONG_MAX_MS  = 7'h64;

  // serial frame
  localparam logic [4:0] FRAME_BITS  = 5'h10;
  localparam logic [4:0] ADDR_DONE   = 5'h07;
  localparam logic [4:0] COUNT_LIMIT = 5'h1f;

  // synchroniser reset pattern {sclk, sdi, scsN, sharedPin}
  localparam logic [3:0] SYNC_RESET = 4'h2;

  // control register map
  localparam int NUM_REGS  = 26;
  localparam int IDX_GEN_A = 0;
  localparam int IDX_GEN_B = 1;

  localparam logic [5:0] REG_ADDR [NUM_REGS] = '{
    6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f,
    6'h10, 6'h11, 6'h12, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c,
    6'h1d, 6'h1f, 6'h20, 6'h23, 6'h25, 6'h26, 6'h27, 6'h28};

  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'h06, 8'h02, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam logic [2:0] LOCK_OPEN = 3'h3;
  localparam logic [2:0] LOCK_SHUT = 3'h6;

  typedef enum logic [1:0] {
    BRIDGE_HALF = 2'h0,
    BRIDGE_PHEN = 2'h1,
    BRIDGE_PWM  = 2'h2,
    BRIDGE_SOL  = 2'h3
  } bridge_mode_t;

  typedef enum logic [1:0] {
    CP_AUTO    = 2'h0,
    CP_DOUBLER = 2'h1,
    CP_TRIPLER = 2'h2,
    CP_RSVD    = 2'h3
  } charge_pump_mode_field_t;

  typedef struct packed {
    logic         driverEnable;
    logic         offlineDiagEnable;
    bridge_mode_t bridgeMode;
    logic [2:0]   lock;
    logic         faultClear;
  } gen_a_t;

  typedef struct packed {
    logic     spreadSpectrumDisable;
    logic     sharedPinMode;
    charge_pump_mode_field_t chargePumpMode;
    logic     watchdogEnable;
    logic     watchdogFaultMode;
    logic     watchdogWindowSelect;
    logic     watchdogRestart;
  } gen_b_t;

  typedef struct packed {
    logic       faultSummary;
    logic       warningSummary;
    logic       watchdogFault;
    logic       frameFault;
    logic       monitorFault;
    logic [2:0] zero;
  } status_t;

  typedef enum logic [2:0] {
    FR_IDLE  = 3'b001,
    FR_SHIFT = 3'b010,
    FR_DONE  = 3'b100
  } frame_state_t;

endpackage : gate_ctrl_pkg

// *** hdl/pin_sync.sv ***
`timescale 1ns/1ps

module pin_sync #(
  parameter int         WIDTH     = 1,
  parameter logic [3:0] RESET_VAL = 4'h0
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // pins
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage_r;

  // stage_r feeds only pinOut, nothing else may look at it
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage_r <= RESET_VAL[WIDTH-1:0];
      pinOut  <= RESET_VAL[WIDTH-1:0];
    end
    else
    begin
      stage_r <= pinIn;
      pinOut  <= stage_r;
    end
  end

endmodule : pin_sync

// *** hdl/window_watchdog.sv ***
`timescale 1ns/1ps

module window_watchdog #(
  parameter int TICK_CYCLES = gate_ctrl_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // control
  input  wire logic enable,
  input  wire logic longWindow,
  input  wire logic restart,
  // event
  output logic      expire
);

  logic [16:0] prescale_r;
  logic [6:0]  msCount_r;
  logic        tickDone;
  logic [6:0]  minMs;
  logic [6:0]  maxMs;
  logic        early;
  logic        late;

  assign tickDone = prescale_r == 17'(TICK_CYCLES - 1);
  assign minMs    = longWindow ? gate_ctrl_pkg::WD_LONG_MIN_MS
                               : gate_ctrl_pkg::WD_SHORT_MIN_MS;
  assign maxMs    = longWindow ? gate_ctrl_pkg::WD_LONG_MAX_MS
                               : gate_ctrl_pkg::WD_SHORT_MAX_MS;
  // a restart before the window opens is as bad as none at all
  assign early    = restart && (msCount_r < minMs);
  // a window shortened mid-count must still expire at the next tick
  assign late     = tickDone && (msCount_r >= maxMs - 7'h01);
  assign expire   = enable && (early || late);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prescale_r <= 17'h00000;
      msCount_r  <= 7'h00;
    end
    else if (!enable || restart || late)
    begin
      prescale_r <= 17'h00000;
      msCount_r  <= 7'h00;
    end
    else if (tickDone)
    begin
      prescale_r <= 17'h00000;
      msCount_r  <= msCount_r + 7'h01;
    end
    else
    begin
      prescale_r <= prescale_r + 17'h00001;
    end
  end

endmodule : window_watchdog

// *** hdl/gate_driver_general_control_regs.sv ***
`timescale 1ns/1ps

module gate_driver_general_control_regs #(
  parameter int TICK_CYCLES = gate_ctrl_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // serial register port
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic        scsN,
  output logic             sdo,
  output logic             sdoOe,
  // shared disable / fault pin
  input  wire logic        sharedPinIn,
  output logic             sharedPinOut,
  output logic             sharedPinOe,
  // device monitors
  input  wire logic        monitorFault,
  output logic             faultClearPulse,
  // driver controls
  output logic             gateDriveEnable,
  output logic             passivePulldown,
  output logic             offlineDiagEnable,
  output logic [1:0]       bridgeMode,
  output logic [1:0]       chargePumpMode,
  output logic             spreadSpectrumDisable
);

  localparam int NR = gate_ctrl_pkg::NUM_REGS;

  logic                        sclkS;
  logic                        sdiS;
  logic                        scsNS;
  logic                        pinS;
  logic                        sclkPrev_r;
  gate_ctrl_pkg::frame_state_t state_r;
  gate_ctrl_pkg::frame_state_t state_nxt;
  logic [4:0]                  bitCnt_r;
  logic [15:0]                 rxShift_r;
  logic [15:0]                 txShift_r;
  logic [7:0]                  regFile_r   [NR];
  logic [7:0]                  regFile_nxt [NR];
  logic                        wdFault_r;
  logic                        frameFault_r;
  logic                        monFault_r;
  logic                        drvEnable_r;
  logic                        pinAssert_r;

  logic                        sclkRise;
  logic                        sclkFall;
  logic                        csActive;
  logic [5:0]                  frameAddr;
  logic                        addrHit;
  logic [4:0]                  hitIdx;
  logic [7:0]                  readData;
  logic                        countOk;
  logic                        writeGo;
  logic                        locked;
  logic [7:0]                  wrData;
  gate_ctrl_pkg::gen_a_t       genA;
  gate_ctrl_pkg::gen_b_t       genB;
  gate_ctrl_pkg::gen_a_t       wrA;
  gate_ctrl_pkg::gen_b_t       wrB;
  gate_ctrl_pkg::status_t      status;
  logic                        clearNow;
  logic                        wdRestart;
  logic                        wdExpire;
  logic                        wdIsFault;
  logic                        globalDisable;
  logic                        drvEnable_nxt;
  logic                        faultSummary;

  pin_sync #(
    .WIDTH     (4),
    .RESET_VAL (gate_ctrl_pkg::SYNC_RESET)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pinIn  ({sclk, sdi, scsN, sharedPinIn}),
    .pinOut ({sclkS, sdiS, scsNS, pinS})
  );

  // serial edges found on the synchronised clock
  assign sclkRise = sclkS && !sclkPrev_r;
  assign sclkFall = !sclkS && sclkPrev_r;
  assign csActive = !scsNS;

  // the address is looked up as its last bit arrives, so a read answer is
  // ready for the second byte; at frame end the stored copy is used
  assign frameAddr = (state_r == gate_ctrl_pkg::FR_SHIFT &&
                      bitCnt_r == gate_ctrl_pkg::ADDR_DONE)
                   ? {rxShift_r[4:0], sdiS} : rxShift_r[13:8];

  always_comb
  begin
    addrHit = 1'b0;
    hitIdx  = 5'h00;
    for (int i = 0; i < NR; i++)
    begin
      if (frameAddr == gate_ctrl_pkg::REG_ADDR[i])
      begin
        addrHit = 1'b1;
        hitIdx  = 5'(i);
      end
    end
  end

  // unmapped offsets read as zero and take no write
  assign readData = addrHit ? regFile_r[hitIdx] : 8'h00;

  assign genA = gate_ctrl_pkg::gen_a_t'(regFile_r[gate_ctrl_pkg::IDX_GEN_A]);
  assign genB = gate_ctrl_pkg::gen_b_t'(regFile_r[gate_ctrl_pkg::IDX_GEN_B]);
  assign wrData = rxShift_r[7:0];
  assign wrA    = gate_ctrl_pkg::gen_a_t'(wrData);
  assign wrB    = gate_ctrl_pkg::gen_b_t'(wrData);

  assign countOk = bitCnt_r == gate_ctrl_pkg::FRAME_BITS;
  assign writeGo = (state_r == gate_ctrl_pkg::FR_DONE) && countOk &&
                   !rxShift_r[14] && addrHit;
  assign locked  = genA.lock == gate_ctrl_pkg::LOCK_SHUT;

  // restart only when the written restart bit differs from the stored one
  assign wdRestart = writeGo && !locked && genB.watchdogEnable &&
                     (hitIdx == 5'(gate_ctrl_pkg::IDX_GEN_B)) &&
                     (wrB.watchdogRestart != genB.watchdogRestart);

  // the clear bit is high for one cycle; that cycle does the clearing
  assign clearNow        = genA.faultClear;
  assign faultClearPulse = clearNow;

  always_comb
  begin
    for (int i = 0; i < NR; i++)
    begin
      regFile_nxt[i] = regFile_r[i];
    end
    regFile_nxt[gate_ctrl_pkg::IDX_GEN_A][0] = 1'b0;
    if (writeGo)
    begin
      if (hitIdx == 5'(gate_ctrl_pkg::IDX_GEN_A))
      begin
        if (!locked)
        begin
          regFile_nxt[gate_ctrl_pkg::IDX_GEN_A] = {wrData[7:4],
                                                   genA.lock,
                                                   wrData[0]};
        end
        // only the two defined codes move the lock field
        if (wrA.lock == gate_ctrl_pkg::LOCK_OPEN ||
            wrA.lock == gate_ctrl_pkg::LOCK_SHUT)
        begin
          regFile_nxt[gate_ctrl_pkg::IDX_GEN_A][3:1] = wrA.lock;
        end
      end
      else if (!locked)
      begin
        regFile_nxt[hitIdx] = wrData;
      end
    end
  end

  window_watchdog #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_watchdog (
    .mclk       (mclk),
    .resetn     (resetn),
    .enable     (genB.watchdogEnable),
    .longWindow (genB.watchdogWindowSelect),
    .restart    (wdRestart),
    .expire     (wdExpire)
  );

  // faults: a new event wins over a clear in the same cycle
  assign wdIsFault    = wdFault_r && genB.watchdogFaultMode;
  assign faultSummary = monFault_r || wdIsFault;

  assign status = '{
    faultSummary:   faultSummary,
    warningSummary: wdFault_r && !genB.watchdogFaultMode,
    watchdogFault:  wdFault_r,
    frameFault:     frameFault_r,
    monitorFault:   monFault_r,
    zero:           3'h0
  };

  // pin at 0 is a driver disable input, active high
  assign globalDisable = !genB.sharedPinMode && pinS;
  assign drvEnable_nxt = genA.driverEnable && !globalDisable &&
                         !wdIsFault;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      gate_ctrl_pkg::FR_IDLE:
      begin
        if (csActive)
        begin
          state_nxt = gate_ctrl_pkg::FR_SHIFT;
        end
      end
      gate_ctrl_pkg::FR_SHIFT:
      begin
        if (!csActive)
        begin
          state_nxt = gate_ctrl_pkg::FR_DONE;
        end
      end
      gate_ctrl_pkg::FR_DONE:
      begin
        state_nxt = gate_ctrl_pkg::FR_IDLE;
      end
      default:
      begin
        state_nxt = gate_ctrl_pkg::FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r    <= gate_ctrl_pkg::FR_IDLE;
      sclkPrev_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      sclkPrev_r <= sclkS;
    end
  end

  // shift path: sample sdi and advance sdo on each falling sclk edge
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      bitCnt_r  <= 5'h00;
      rxShift_r <= 16'h0000;
      txShift_r <= 16'h0000;
    end
    else if (state_r == gate_ctrl_pkg::FR_IDLE)
    begin
      bitCnt_r  <= 5'h00;
      txShift_r <= {status, 8'h00};
    end
    else if (state_r == gate_ctrl_pkg::FR_SHIFT && sclkFall)
    begin
      rxShift_r <= {rxShift_r[14:0], sdiS};
      if (bitCnt_r != gate_ctrl_pkg::COUNT_LIMIT)
      begin
        bitCnt_r <= bitCnt_r + 5'h01;
      end
      if (bitCnt_r == gate_ctrl_pkg::ADDR_DONE)
      begin
        txShift_r <= {readData, 8'h00};
      end
      else
      begin
        txShift_r <= {txShift_r[14:0], 1'b0};
      end
    end
  end

  // register file, reset values from the map
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NR; i++)
      begin
        regFile_r[i] <= gate_ctrl_pkg::REG_RESET[i];
      end
    end
    else
    begin
      for (int i = 0; i < NR; i++)
      begin
        regFile_r[i] <= regFile_nxt[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wdFault_r    <= 1'b0;
      frameFault_r <= 1'b0;
      monFault_r   <= 1'b0;
    end
    else
    begin
      wdFault_r    <= wdExpire || (wdFault_r && !clearNow);
      frameFault_r <= ((state_r == gate_ctrl_pkg::FR_DONE) && !countOk) ||
                      (frameFault_r && !clearNow);
      monFault_r   <= monitorFault || (monFault_r && !clearNow);
    end
  end

  // outputs toward the drivers and pins
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      drvEnable_r <= 1'b0;
      pinAssert_r <= 1'b0;
    end
    else
    begin
      drvEnable_r <= drvEnable_nxt;
      // open-drain low only in fault-output mode
      pinAssert_r <= genB.sharedPinMode && faultSummary;
    end
  end

  assign gateDriveEnable       = drvEnable_r;
  assign passivePulldown       = !drvEnable_r;
  assign offlineDiagEnable     = genA.offlineDiagEnable;
  assign bridgeMode            = genA.bridgeMode;
  // the reserved code falls back to automatic switching
  assign chargePumpMode        = (genB.chargePumpMode ==
                                  gate_ctrl_pkg::CP_RSVD)
                               ? gate_ctrl_pkg::CP_AUTO
                               : genB.chargePumpMode;
  assign spreadSpectrumDisable = genB.spreadSpectrumDisable;
  assign sharedPinOut          = 1'b0;
  assign sharedPinOe           = pinAssert_r;
  assign sdo                   = txShift_r[15];
  assign sdoOe                 = csActive;

endmodule : gate_driver_general_control_regs

// *** tb/gate_regs_checker_sva.sv ***
`timescale 1ns/1ps

module gate_regs_checker #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic       mclk,
  input wire logic       resetn,
  // watched ports
  input wire logic       scsN,
  input wire logic       sharedPinOut,
  input wire logic       faultClearPulse,
  input wire logic       gateDriveEnable,
  input wire logic       passivePulldown,
  input wire logic       offlineDiagEnable,
  input wire logic [1:0] bridgeMode,
  input wire logic [1:0] chargePumpMode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  pulldown_inverse_a: assert property
    (passivePulldown == !gateDriveEnable)
    else $error("pulldown not inverse of drive enable");
  clear_single_a: assert property (faultClearPulse |=> !faultClearPulse)
    else $error("fault clear held longer than one cycle");
  clear_idle_a: assert property (faultClearPulse |-> scsN)
    else $error("fault clear inside a frame");
  open_drain_a: assert property (sharedPinOut == 1'b0)
    else $error("shared pin driven high");
  pump_reserved_a: assert property (chargePumpMode != 2'h3)
    else $error("reserved pump code reached output");
  // a write lands a few cycles after select rises, never deep in a frame
  mode_frame_a: assert property (!scsN [*6] |-> $stable(bridgeMode))
    else $error("bridge mode changed inside a frame");
  diag_frame_a: assert property
    (!scsN [*6] |-> $stable(offlineDiagEnable))
    else $error("diagnostic enable changed inside a frame");
  pump_frame_a: assert property (!scsN [*6] |-> $stable(chargePumpMode))
    else $error("pump mode changed inside a frame");
endmodule : gate_regs_checker

bind gate_driver_general_control_regs gate_regs_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) i_chk (
  .mclk(mclk), .resetn(resetn), .scsN(scsN), .sharedPinOut(sharedPinOut),
  .faultClearPulse(faultClearPulse), .gateDriveEnable(gateDriveEnable),
  .passivePulldown(passivePulldown), .offlineDiagEnable(offlineDiagEnable),
  .bridgeMode(bridgeMode), .chargePumpMode(chargePumpMode)
);

// *** tb/serial_host.sv ***
`timescale 1ns/1ps

module serial_host (
  // serial link
  output logic      sclk,
  output logic      sdi,
  output logic      scsN,
  input  wire logic sdo
);
  initial
  begin
    sclk = 1'b0;
    sdi  = 1'b0;
    scsN = 1'b1;
  end

  // data moves mid low phase, clear of the falling edge the device samples
  task automatic frame(input logic [15:0] w, input int n,
                       output logic [15:0] r);
    r = 16'h0000;
    scsN = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #40 sdi = w[15-i];
      #40 sclk = 1'b1;
      #80 r = {r[14:0], sdo};
      sclk = 1'b0;
    end
    #80 scsN = 1'b1;
    sdi = ~sdi;
    #200;
  endtask : frame
endmodule : serial_host

// *** tb/gate_driver_general_control_regs_bench.sv ***
`timescale 1ns/1ps

module gate_driver_general_control_regs_bench;
  localparam int TICKS = 20;
  logic        mclk, resetn, sclk, sdi, scsN, sdo, sdoOe, monitorFault;
  logic        sharedPinIn, sharedPinOut, sharedPinOe, hostDisable;
  logic        faultClearPulse, gateDriveEnable, passivePulldown;
  logic        offlineDiagEnable, spreadSpectrumDisable;
  logic [1:0]  bridgeMode, chargePumpMode;
  logic [15:0] resp;
  int          errors, testsRun, pulses;

  // pin is pulled low by the device, otherwise driven from outside
  assign sharedPinIn = sharedPinOe ? 1'b0 : hostDisable;

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (faultClearPulse === 1'b1) pulses++;

  gate_driver_general_control_regs #(.TICK_CYCLES(TICKS)) i_dut (
    .mclk(mclk), .resetn(resetn), .sclk(sclk), .sdi(sdi), .scsN(scsN),
    .sdo(sdo), .sdoOe(sdoOe), .sharedPinIn(sharedPinIn),
    .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe),
    .monitorFault(monitorFault), .faultClearPulse(faultClearPulse),
    .gateDriveEnable(gateDriveEnable), .passivePulldown(passivePulldown),
    .offlineDiagEnable(offlineDiagEnable), .bridgeMode(bridgeMode),
    .chargePumpMode(chargePumpMode),
    .spreadSpectrumDisable(spreadSpectrumDisable)
  );

  // a released data line shows the inverse, so a late enable is caught
  serial_host i_host (.sclk(sclk), .sdi(sdi), .scsN(scsN),
                      .sdo(sdoOe ? sdo : ~sdo));

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task xfer(input logic rd, input logic [5:0] a, input logic [7:0] d,
            input int n = 16);
    @(negedge mclk);
    i_host.frame({1'b0, rd, a, d}, n, resp);
  endtask : xfer

  task rdc(input string name, input logic [5:0] a, input logic [7:0] exp);
    xfer(1'b1, a, 8'h00);
    check(name, resp[7:0], exp);
  endtask : rdc

  task complete_run;
    $display("errors %0d checks %0d", errors, testsRun);
    if (errors == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  initial
  begin
    #400000;
    errors++;
    complete_run();
  end

  initial
  begin
    mclk = 1'b0;
    resetn = 1'b0;
    monitorFault = 1'b0;
    hostDisable = 1'b0;
    errors = 0;
    testsRun = 0;
    pulses = 0;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    repeat (5) @(negedge mclk);
    rdc("gen_a", 6'h07, 8'h06);
    rdc("gen_b", 6'h08, 8'h02);
    rdc("unmapped", 6'h13, 8'h00);
    check("pulldown", {7'h00, passivePulldown}, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, 6'h07, {2'b11, 2'(i), 4'h6});
      check("bridge", {6'h00, bridgeMode}, 8'(i));
      check("diag", {7'h00, offlineDiagEnable}, 8'h01);
      check("drive", {6'h00, gateDriveEnable, passivePulldown}, 8'h02);
      xfer(1'b0, 6'h08, {2'b00, 2'(i), 4'h2});
      check("pump", {6'h00, chargePumpMode}, (i == 3) ? 8'h00 : 8'(i));
    end
    rdc("gen_a", 6'h07, 8'hf6);
    xfer(1'b0, 6'h07, 8'h0c);
    xfer(1'b0, 6'h07, 8'hba);
    xfer(1'b0, 6'h08, 8'h80);
    check("locked", {5'h00, spreadSpectrumDisable, bridgeMode}, 8'h00);
    rdc("lock", 6'h07, 8'h0c);
    xfer(1'b0, 6'h07, 8'h36);
    rdc("unlock", 6'h07, 8'h06);
    xfer(1'b0, 6'h08, 8'h82);
    check("ssc", {7'h00, spreadSpectrumDisable}, 8'h01);
    xfer(1'b0, 6'h07, 8'h30);
    check("open", {6'h00, bridgeMode}, 8'h03);
    @(negedge mclk) monitorFault = 1'b1;
    @(negedge mclk) monitorFault = 1'b0;
    // a frame one clock short is refused and flagged
    xfer(1'b0, 6'h07, 8'h00, 15);
    xfer(1'b1, 6'h07, 8'h00);
    check("faults", resp[15:8] & 8'h18, 8'h18);
    pulses = 0;
    xfer(1'b0, 6'h07, 8'h87);
    rdc("cleared", 6'h07, 8'h86);
    check("status", resp[15:8] & 8'h38, 8'h00);
    check("pulse", 8'(pulses), 8'h01);
    xfer(1'b0, 6'h08, 8'h0a);
    xfer(1'b0, 6'h08, 8'h0b);
    rdc("restart", 6'h08, 8'h0b);
    xfer(1'b0, 6'h08, 8'h0a);
    rdc("restart", 6'h08, 8'h0a);
    check("wd quiet", resp[15:8] & 8'h20, 8'h00);
    // past the window from enable, short of it from the last restart
    repeat (1600) @(negedge mclk);
    xfer(1'b1, 6'h08, 8'h00);
    check("wd held", resp[15:8] & 8'h20, 8'h00);
    repeat (500) @(negedge mclk);
    xfer(1'b1, 6'h08, 8'h00);
    check("wd warn", resp[15:8] & 8'he0, 8'h60);
    check("wd mode0", {6'h00, gateDriveEnable, sharedPinOe}, 8'h02);
    xfer(1'b0, 6'h07, 8'h87);
    xfer(1'b0, 6'h08, 8'h4c);
    repeat (900) @(negedge mclk);
    check("wd mode1", {6'h00, gateDriveEnable, sharedPinOe}, 8'h01);
    xfer(1'b1, 6'h08, 8'h00);
    check("wd summary", resp[15:8] & 8'ha0, 8'ha0);
    xfer(1'b0, 6'h08, 8'h02);
    xfer(1'b0, 6'h07, 8'h87);
    repeat (2100) @(negedge mclk);
    xfer(1'b1, 6'h08, 8'h00);
    check("wd off", resp[15:8] & 8'h20, 8'h00);
    hostDisable = 1'b1;
    repeat (6) @(negedge mclk);
    check("pin off", {7'h00, gateDriveEnable}, 8'h00);
    hostDisable = 1'b0;
    repeat (6) @(negedge mclk);
    check("pin on", {7'h00, gateDriveEnable}, 8'h01);
    complete_run();
  end
endmodule : gate_driver_general_control_regs_bench
